// [hdl/pin_function_mux.sv]
// Purpose: per-pin function multiplexer with AXI4-Lite register access
// Assumes: single clock aclk, synchronous active-low reset, pads sampled through sync2
// Notes: pad outputs are registered, one cycle behind the register state
// Notes on behaviour
// R1: after reset every pin belongs to general I/O; no peripheral drives it.
// R2: each pin 0..31 has an enable bit; set means peripheral function connects.
// R3: function choice sits in pair registers: even field and odd field.
// R4: function B is analog; selecting it cuts digital input and output.
// R5: an enabled analog peripheral disturbs other functions of its pin.
// R6: oscillator pins bypass the mux; only oscillator controllers route them.
// R7: only the debug clock pin uses the mux; debug data pin has none.
// R8: debugger detection switches the debug data pin over without software.
// R9: two-wire serial mode works only on a restricted set of pins.
// R10: without USB the USB function selections give no function.
// R11: a non-maskable interrupt pin input goes to the interrupt controller.
// R12: eight external wake inputs go to the reset controller.
// R13: generic clock pins are bidirectional: clock in or generator out.
// R14: an active-low reset input pin goes to the power manager.
// R15: a main supply good input goes to the supply controller.
// R16: three control timers; several waveform outputs may share one channel.
// R17: enable set: peripheral drives pin; clear: general I/O registers drive it.
module pin_function_mux #(
	parameter logic [31:0] OSC_PIN_MASK = 32'h0000_0000,
	parameter logic [31:0] I2C_PIN_MASK = 32'h000F_F000,
	parameter logic [31:0] USB_PIN_MASK = 32'h0380_0000,
	parameter bit USB_PRESENT = 1'b1,
	parameter int NMI_PIN = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [31:0] pad_in,
	output logic [31:0] pad_out,
	output logic [31:0] pad_oe,
	output logic [31:0] pad_ie,
	output logic [31:0] analog_connect,
	input wire logic [31:0] analog_busy,
	output logic [31:0] analog_disturb,
	input wire logic [pin_mux_pkg::NUM_FUNC*32-1:0] periph_out,
	input wire logic [pin_mux_pkg::NUM_FUNC*32-1:0] periph_oe,
	output logic [pin_mux_pkg::NUM_FUNC*32-1:0] periph_in,
	input wire logic [31:0] i2c_mode,
	input wire logic [31:0] osc_own,
	input wire logic [31:0] osc_pad_out,
	input wire logic [31:0] osc_pad_oe,
	input wire logic swdio_pad_in,
	output logic swdio_pad_out,
	output logic swdio_pad_oe,
	input wire logic debugger_detect,
	input wire logic dbg_swdio_out,
	input wire logic dbg_swdio_oe,
	output logic dbg_swdio_in,
	output logic [pin_mux_pkg::NUM_IRQ-1:0] ext_irq_line,
	output logic nmi_irq,
	output logic [pin_mux_pkg::NUM_WAKE-1:0] ext_wake_in,
	input wire logic reset_pad_n,
	output logic reset_in_n,
	input wire logic supply_good_pad,
	output logic main_supply_good,
	input wire logic [pin_mux_pkg::NUM_TIMERS*pin_mux_pkg::TIMER_CC_NUM-1:0] timer_cc_event,
	output logic [pin_mux_pkg::NUM_TIMERS*pin_mux_pkg::TIMER_WO_NUM-1:0] waveform_out
);
	localparam int NF = pin_mux_pkg::NUM_FUNC;
	localparam int NP = pin_mux_pkg::NUM_PINS;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// pair registers start at the select base, one word per pin pair
	function automatic logic sel_hit(input logic [7:0] a);
		return a >= pin_mux_pkg::OFF_SELECT_BASE &&
			a < pin_mux_pkg::OFF_SELECT_BASE + 8'(4 * pin_mux_pkg::SELECT_REGS);
	endfunction

	function automatic logic [3:0] sel_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - pin_mux_pkg::OFF_SELECT_BASE;
		return d[5:2];
	endfunction

	// register state
	logic [31:0] mux_enable_ff;
	logic [31:0] gpio_out_ff;
	logic [31:0] gpio_dir_ff;
	logic [7:0] select_ff [pin_mux_pkg::SELECT_REGS];
	logic debug_attached_ff;

	// bus state
	logic aw_got_ff;
	logic w_got_ff;
	logic [pin_mux_pkg::ADDR_W-1:0] aw_addr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// pad and output state
	logic [31:0] pad_out_ff;
	logic [31:0] pad_oe_ff;
	logic [31:0] pad_ie_ff;
	logic [31:0] analog_ff;
	logic [31:0] disturb_ff;
	logic [NF*32-1:0] periph_in_ff;
	logic [pin_mux_pkg::NUM_IRQ-1:0] irq_ff;
	logic nmi_ff;
	logic [pin_mux_pkg::NUM_WAKE-1:0] wake_ff;
	logic swdio_out_ff;
	logic swdio_oe_ff;
	logic swdio_in_ff;
	logic [pin_mux_pkg::NUM_TIMERS*pin_mux_pkg::TIMER_WO_NUM-1:0] wo_ff;

	logic [35:0] sync_bus;
	wire [31:0] pad_sync = sync_bus[31:0];
	wire swdio_sync = sync_bus[32];
	wire detect_sync = sync_bus[33];

	sync2 #(.WIDTH(36)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({supply_good_pad, reset_pad_n, debugger_detect, swdio_pad_in, pad_in}),
		.sync_out(sync_bus)
	);

	// reset pin and supply good pass straight from the synchroniser
	assign reset_in_n = sync_bus[34]; // [R14]
	assign main_supply_good = sync_bus[35]; // [R15]

	// per-pin routing
	logic [31:0] c_out;
	logic [31:0] c_oe;
	logic [31:0] c_ie;
	logic [31:0] c_analog;
	logic [NF*32-1:0] c_fin;

	genvar i;
	genvar f;
	generate
		for (i = 0; i < NP; i++) begin : g_pin
			logic [NF-1:0] pout;
			logic [NF-1:0] poe;
			logic [NF-1:0] fin;
			wire [7:0] pair = select_ff[i/2];
			// even pin takes the low field, odd pin the high field
			wire [3:0] sel = (i % 2 == 0) ? pair[pin_mux_pkg::EVEN_LSB +: 4] :
				pair[pin_mux_pkg::ODD_LSB +: 4]; // [R3]
			for (f = 0; f < NF; f++) begin : g_f
				assign pout[f] = periph_out[f*32 + i];
				assign poe[f] = periph_oe[f*32 + i];
				assign c_fin[f*32 + i] = fin[f];
			end
			pin_cell #(
				.OSC_PIN(OSC_PIN_MASK[i]),
				.I2C_OK(I2C_PIN_MASK[i]),
				.USB_PIN(USB_PIN_MASK[i]),
				.USB_PRESENT(USB_PRESENT)
			) u_cell (
				.mux_enable(mux_enable_ff[i]),
				.select(sel),
				.gpio_out(gpio_out_ff[i]),
				.gpio_oe(gpio_dir_ff[i]),
				.periph_out(pout),
				.periph_oe(poe),
				.i2c_mode(i2c_mode[i]),
				.osc_own(osc_own[i]),
				.osc_out(osc_pad_out[i]),
				.osc_oe(osc_pad_oe[i]),
				.pad_in(pad_sync[i]),
				.pad_out(c_out[i]),
				.pad_oe(c_oe[i]),
				.pad_ie(c_ie[i]),
				.analog_on(c_analog[i]),
				.func_in(fin)
			);
		end
		for (i = 0; i < pin_mux_pkg::NUM_TIMERS * pin_mux_pkg::TIMER_WO_NUM; i++) begin : g_wo
			// outputs beyond the channel count reuse a channel's compare
			localparam int T = i / pin_mux_pkg::TIMER_WO_NUM;
			localparam int K = (i % pin_mux_pkg::TIMER_WO_NUM) % pin_mux_pkg::TIMER_CC_NUM;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					wo_ff[i] <= 1'b0;
				end else begin
					wo_ff[i] <= timer_cc_event[T*pin_mux_pkg::TIMER_CC_NUM + K]; // [R16]
				end
			end
		end
	endgenerate

	// function A inputs feed the interrupt and wake lines
	logic [pin_mux_pkg::NUM_IRQ-1:0] nxt_irq;
	logic nxt_nmi;
	logic [pin_mux_pkg::NUM_WAKE-1:0] nxt_wake;
	always_comb begin
		nxt_irq = '0;
		nxt_nmi = 1'b0;
		nxt_wake = '0;
		for (int p = 0; p < NP; p++) begin
			if (p == NMI_PIN) begin
				nxt_nmi = nxt_nmi | c_fin[p]; // [R11]
			end else begin
				nxt_irq[p % pin_mux_pkg::NUM_IRQ] = nxt_irq[p % pin_mux_pkg::NUM_IRQ] | c_fin[p];
			end
			if (p < pin_mux_pkg::NUM_WAKE) begin
				nxt_wake[p] = c_fin[p]; // [R12]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_out_ff <= '0;
			pad_oe_ff <= '0;
			pad_ie_ff <= '0;
			analog_ff <= '0;
			disturb_ff <= '0;
			periph_in_ff <= '0;
			irq_ff <= '0;
			nmi_ff <= 1'b0;
			wake_ff <= '0;
		end else begin
			pad_out_ff <= c_out;
			pad_oe_ff <= c_oe; // [R1] [R17]
			pad_ie_ff <= c_ie;
			analog_ff <= c_analog;
			// busy analog output spoils whatever digital function shares the pin
			disturb_ff <= analog_busy & ~c_analog; // [R5]
			periph_in_ff <= c_fin;
			irq_ff <= nxt_irq;
			nmi_ff <= nxt_nmi;
			wake_ff <= nxt_wake;
		end
	end

	// debug data pin is outside the mux; the debug clock pin is an ordinary pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			debug_attached_ff <= 1'b0;
			swdio_out_ff <= 1'b0;
			swdio_oe_ff <= 1'b0;
			swdio_in_ff <= 1'b0;
		end else begin
			debug_attached_ff <= debug_attached_ff | detect_sync; // [R8]
			swdio_out_ff <= debug_attached_ff & dbg_swdio_out; // [R7] [R8]
			swdio_oe_ff <= debug_attached_ff & dbg_swdio_oe; // [R7] [R8]
			swdio_in_ff <= debug_attached_ff & swdio_sync;
		end
	end

	// AXI4-Lite write path
	assign awready = !aw_got_ff && !bvalid_ff;
	assign wready = !w_got_ff && !bvalid_ff;
	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire do_write = aw_got_ff && w_got_ff;
	wire [5:0] wr_word = aw_addr_ff[7:2];
	wire wr_sel = sel_hit(aw_addr_ff);
	wire wr_en = wr_word == pin_mux_pkg::OFF_MUX_ENABLE[7:2];
	wire wr_out = wr_word == pin_mux_pkg::OFF_GPIO_OUT[7:2];
	wire wr_dir = wr_word == pin_mux_pkg::OFF_GPIO_DIR[7:2];
	wire wr_ro = wr_word == pin_mux_pkg::OFF_GPIO_IN[7:2] ||
		wr_word == pin_mux_pkg::OFF_STATUS[7:2] || wr_word == pin_mux_pkg::OFF_ANALOG_DISTURB[7:2];
	wire wr_ok = wr_sel || wr_en || wr_out || wr_dir || wr_ro;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= pin_mux_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end
			if (w_take) begin
				w_got_ff <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_DECERR;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mux_enable_ff <= pin_mux_pkg::RST_MUX_ENABLE; // [R1]
			gpio_out_ff <= pin_mux_pkg::RST_GPIO_OUT;
			gpio_dir_ff <= pin_mux_pkg::RST_GPIO_DIR;
			for (int s = 0; s < pin_mux_pkg::SELECT_REGS; s++) begin
				select_ff[s] <= pin_mux_pkg::RST_SELECT;
			end
		end else if (do_write) begin
			if (wr_en) begin
				mux_enable_ff <= merge(mux_enable_ff, wdata_ff, wstrb_ff); // [R2]
			end
			if (wr_out) begin
				gpio_out_ff <= merge(gpio_out_ff, wdata_ff, wstrb_ff);
			end
			if (wr_dir) begin
				gpio_dir_ff <= merge(gpio_dir_ff, wdata_ff, wstrb_ff);
			end
			// only the low byte lane carries the pair fields
			if (wr_sel && wstrb_ff[0]) begin
				select_ff[sel_index(aw_addr_ff)] <= wdata_ff[7:0]; // [R3]
			end
		end
	end

	// AXI4-Lite read path
	assign arready = !rvalid_ff;
	wire ar_take = arvalid && arready;
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (sel_hit(araddr)) begin
			rd_word = {24'h00_0000, select_ff[sel_index(araddr)]};
		end else begin
			case (araddr[7:2])
				pin_mux_pkg::OFF_MUX_ENABLE[7:2]: rd_word = mux_enable_ff;
				pin_mux_pkg::OFF_GPIO_OUT[7:2]: rd_word = gpio_out_ff;
				pin_mux_pkg::OFF_GPIO_DIR[7:2]: rd_word = gpio_dir_ff;
				pin_mux_pkg::OFF_GPIO_IN[7:2]: rd_word = pad_sync & pad_ie_ff;
				pin_mux_pkg::OFF_STATUS[7:2]: begin
					rd_word[pin_mux_pkg::STATUS_DEBUG_BIT] = debug_attached_ff;
					rd_word[pin_mux_pkg::STATUS_USB_BIT] = USB_PRESENT;
				end
				pin_mux_pkg::OFF_ANALOG_DISTURB[7:2]: rd_word = disturb_ff;
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= pin_mux_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_ok ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_DECERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign pad_out = pad_out_ff;
	assign pad_oe = pad_oe_ff;
	assign pad_ie = pad_ie_ff;
	assign analog_connect = analog_ff;
	assign analog_disturb = disturb_ff;
	assign periph_in = periph_in_ff;
	assign ext_irq_line = irq_ff;
	assign nmi_irq = nmi_ff;
	assign ext_wake_in = wake_ff;
	assign swdio_pad_out = swdio_out_ff;
	assign swdio_pad_oe = swdio_oe_ff;
	assign dbg_swdio_in = swdio_in_ff;
	assign waveform_out = wo_ff;

	sequence s_enable_write;
		do_write && wr_en && wstrb_ff[0] && wdata_ff[0];
	endsequence
	sequence s_pin0_gpio;
		!mux_enable_ff[0] && !OSC_PIN_MASK[0];
	endsequence

	property p_reset_gpio;
		@(posedge aclk) $past(!aresetn) && aresetn |-> mux_enable_ff == 32'h0000_0000 && !bvalid_ff;
	endproperty
	a_reset_gpio: assert property (p_reset_gpio) else $error("enable not clear after reset"); // [R1]

	property p_enable_write;
		@(posedge aclk) disable iff (!aresetn) s_enable_write |=> mux_enable_ff[0] && bvalid_ff;
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // [R2]

	property p_analog_cut;
		@(posedge aclk) disable iff (!aresetn) analog_ff[0] |-> !pad_ie_ff[0] && !pad_oe_ff[0];
	endproperty
	a_analog_cut: assert property (p_analog_cut) else $error("analog pin still digital"); // [R4]

	property p_disturb;
		@(posedge aclk) disable iff (!aresetn)
			analog_busy[2] && !c_analog[2] |=> disturb_ff[2];
	endproperty
	a_disturb: assert property (p_disturb) else $error("disturb flag missing"); // [R5]

	property p_debug_switch;
		@(posedge aclk) disable iff (!aresetn)
			detect_sync ##1 dbg_swdio_oe [*2] |-> ##1 swdio_pad_oe;
	endproperty
	a_debug_switch: assert property (p_debug_switch) else $error("debug pin not switched"); // [R8]

	property p_two_wire_block;
		@(posedge aclk) disable iff (!aresetn)
			!I2C_PIN_MASK[1] && i2c_mode[1] && mux_enable_ff[1] &&
			select_ff[0][7:4] == pin_mux_pkg::FUNC_D |=> !pad_oe_ff[1];
	endproperty
	a_two_wire_block: assert property (p_two_wire_block) else $error("two-wire on bad pin"); // [R9]

	property p_reset_pin;
		@(posedge aclk) disable iff (!aresetn)
			$past(aresetn, 2) && $past(aresetn) |-> reset_in_n == $past(reset_pad_n, 2);
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin path wrong"); // [R14]

	property p_gpio_path;
		@(posedge aclk) disable iff (!aresetn)
			s_pin0_gpio |=> pad_oe_ff[0] == $past(gpio_dir_ff[0]) &&
			pad_out_ff[0] == $past(gpio_out_ff[0]);
	endproperty
	a_gpio_path: assert property (p_gpio_path) else $error("general I/O not routed"); // [R17]

	property p_bresp_hold;
		@(posedge aclk) disable iff (!aresetn) bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped"); // [R2]
endmodule

// [hdl/pin_mux_pkg.sv]
// Purpose: shared constants of the pin function multiplexer
// Assumes: 32 pins, nine peripheral functions A..I, 32-bit register bus
// Notes: register offsets are byte addresses of aligned words
package pin_mux_pkg;
	localparam int NUM_PINS = 32;
	localparam int NUM_FUNC = 9;
	localparam int SEL_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_IRQ = 16;
	localparam int NUM_WAKE = 8;
	localparam int NUM_TIMERS = 3;
	localparam int TIMER_CC_NUM = 4;
	localparam int TIMER_WO_NUM = 8;
	localparam int SELECT_REGS = 16;
	localparam int EVEN_LSB = 0;
	localparam int ODD_LSB = 4;
	localparam int STATUS_DEBUG_BIT = 0;
	localparam int STATUS_USB_BIT = 1;

	localparam logic [3:0] FUNC_A = 4'h0;
	localparam logic [3:0] FUNC_B = 4'h1;
	localparam logic [3:0] FUNC_C = 4'h2;
	localparam logic [3:0] FUNC_D = 4'h3;
	localparam logic [3:0] FUNC_G = 4'h6;
	localparam logic [3:0] FUNC_H = 4'h7;

	localparam logic [7:0] OFF_MUX_ENABLE = 8'h00;
	localparam logic [7:0] OFF_GPIO_OUT = 8'h04;
	localparam logic [7:0] OFF_GPIO_DIR = 8'h08;
	localparam logic [7:0] OFF_GPIO_IN = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_ANALOG_DISTURB = 8'h14;
	localparam logic [7:0] OFF_SELECT_BASE = 8'h20;

	localparam logic [31:0] RST_MUX_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_GPIO_OUT = 32'h0000_0000;
	localparam logic [31:0] RST_GPIO_DIR = 32'h0000_0000;
	localparam logic [7:0] RST_SELECT = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [hdl/sync2.sv]
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent level, not a bus word
// Notes: first stage feeds only the second stage
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_out = stage2_ff;
endmodule

// [hdl/pin_cell.sv]
// Purpose: routing of one pin between general I/O and its peripheral functions
// Assumes: pad_in already synchronised; purely combinational
// Notes: parameters describe what this pin offers
module pin_cell #(
	parameter bit OSC_PIN = 1'b0,
	parameter bit I2C_OK = 1'b0,
	parameter bit USB_PIN = 1'b0,
	parameter bit USB_PRESENT = 1'b1
) (
	input wire logic mux_enable,
	input wire logic [pin_mux_pkg::SEL_W-1:0] select,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	input wire logic [pin_mux_pkg::NUM_FUNC-1:0] periph_out,
	input wire logic [pin_mux_pkg::NUM_FUNC-1:0] periph_oe,
	input wire logic i2c_mode,
	input wire logic osc_own,
	input wire logic osc_out,
	input wire logic osc_oe,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_ie,
	output logic analog_on,
	output logic [pin_mux_pkg::NUM_FUNC-1:0] func_in
);
	wire osc_take = OSC_PIN && osc_own; // [R6]
	wire sel_valid = select < pin_mux_pkg::SEL_W'(pin_mux_pkg::NUM_FUNC);
	// oscillator pins never enter the function mux
	wire mux_on = mux_enable && sel_valid && !OSC_PIN; // [R2] [R6]
	wire is_analog = mux_on && (select == pin_mux_pkg::FUNC_B); // [R4]
	wire is_serial = mux_on && (select == pin_mux_pkg::FUNC_C || select == pin_mux_pkg::FUNC_D);
	wire two_wire = is_serial && i2c_mode;
	wire usb_gone = USB_PIN && !USB_PRESENT && (select == pin_mux_pkg::FUNC_G); // [R10]
	wire func_blocked = is_analog || usb_gone || (two_wire && !I2C_OK); // [R4] [R9] [R10]
	wire p_out = sel_valid ? periph_out[select] : 1'b0;
	wire p_oe = sel_valid ? periph_oe[select] : 1'b0;
	// two-wire mode only ever pulls low, so the pad is open drain
	wire p_oe_eff = two_wire ? (p_oe && !p_out) : p_oe;
	wire p_out_eff = two_wire ? 1'b0 : p_out;

	// an owning oscillator comes first; a peripheral owns the pin only while its enable is set, else general I/O
	assign pad_out = osc_take ? osc_out : (mux_on ? p_out_eff : gpio_out); // [R17]
	assign pad_oe = osc_take ? osc_oe : (mux_on ? (p_oe_eff && !func_blocked) : gpio_oe); // [R17]
	assign pad_ie = !is_analog && !osc_take; // [R4]
	assign analog_on = is_analog;

	genvar f;
	generate
		for (f = 0; f < pin_mux_pkg::NUM_FUNC; f++) begin : g_fin
			// function H is the bidirectional clock pin: input side here, output above
			assign func_in[f] = mux_on && (select == sel_cast(f)) && !func_blocked && pad_in; // [R13] [R17]
		end
	endgenerate

	function automatic logic [pin_mux_pkg::SEL_W-1:0] sel_cast(input int v);
		return v[pin_mux_pkg::SEL_W-1:0];
	endfunction
endmodule

// [verification/periph_model.sv]
// Purpose: peripheral side model feeding every function output
// Assumes: each function drives a fixed pattern of its own
// Notes: distinct patterns so a wrong selection shows at the pad
module periph_model (
	output logic [pin_mux_pkg::NUM_FUNC*32-1:0] periph_out,
	output logic [pin_mux_pkg::NUM_FUNC*32-1:0] periph_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		for (int f = 0; f < pin_mux_pkg::NUM_FUNC; f++) begin
			periph_out[f*32 +: 32] = 32'h5A5A_0F0F ^ {8{f[3:0]}};
			periph_oe[f*32 +: 32] = 32'hFFFF_FFFF;
		end
	end
endmodule

// [verification/pin_function_mux_test.sv]
// Purpose: self-checking bench of the pin function multiplexer
// Assumes: pin 4 is an oscillator pin, USB absent; this module is the bus master
// Notes: pad checks wait out the three-edge pad path
module pin_function_mux_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, nmi_irq;
	logic [7:0] awaddr, araddr, ext_wake_in;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] wdata, rdata, pad_in, pad_out, pad_oe, pad_ie, rv;
	logic [31:0] analog_connect, analog_busy, analog_disturb, i2c_mode;
	logic [31:0] osc_own, osc_pad_out, osc_pad_oe;
	logic [287:0] periph_out, periph_oe, periph_in;
	logic swdio_pad_in, swdio_pad_out, swdio_pad_oe, debugger_detect;
	logic dbg_swdio_out, dbg_swdio_oe, dbg_swdio_in;
	logic reset_pad_n, reset_in_n, supply_good_pad, main_supply_good;
	logic [15:0] ext_irq_line;
	logic [11:0] timer_cc_event;
	logic [23:0] waveform_out;
	int n_tests = 0;
	int fail_count = 0;

	pin_function_mux #(.OSC_PIN_MASK(32'h0000_0010), .USB_PRESENT(1'b0)) u_pin_function_mux (.*);
	periph_model u_periph_model (.*);

	always #10 aclk = ~aclk;

	function automatic logic [31:0] pat(input logic [3:0] f);
		return 32'h5A5A_0F0F ^ {8{f}};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// a wait that runs out ends the run as a mismatch
	task automatic give_up(input int n);
		if (n >= 60) begin
			fail_count++;
			stop_test();
		end
	endtask

	task automatic settle();
		repeat (5) @(posedge aclk);
	endtask

	// local flags: the valid regs do not show the new value in this step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		int n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			n++;
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
			give_up(n);
		end
		do begin
			@(posedge aclk);
			n++;
			give_up(n);
		end while (!bvalid);
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			give_up(n);
		end while (!arready);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
			give_up(n);
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	task automatic t_reset();
		chk("pad_oe", pad_oe, 32'h0);
		chk("pad_ie", pad_ie, 32'hFFFF_FFFF);
		chk("periph_in", periph_in[31:0], 32'h0);
		rd(8'h00, rv, rs);
		chk("mux_enable", rv, 32'h0);
		rd(8'hFC, rv, rs);
		chk("unmapped", {30'h0, rs}, {30'h0, pin_mux_pkg::RESP_DECERR});
		// late bready: the answer must stand until it is accepted
		bready <= 1'b0;
		wr(8'hFC, 32'h0000_0000, rs);
		bready <= 1'b1;
		@(posedge aclk);
		chk("wr_unmapped", {30'h0, rs}, {30'h0, pin_mux_pkg::RESP_DECERR});
		$display("test reset done");
	endtask

	task automatic t_mux();
		logic [31:0] pc, pd;
		pc = pat(4'h2);
		pd = pat(4'h3);
		wr(8'h08, 32'hFFFF_FFFF, rs);
		wr(8'h04, 32'h1234_567B, rs);
		settle();
		chk("gpio_out", pad_out, 32'h1234_567B);
		chk("gpio_oe", pad_oe, 32'hFFFF_FFFF);
		// pin 0 on C, pin 1 on D; pin 2 in the next pair stays plain I/O
		wr(8'h20, 32'h0000_0032, rs);
		wr(8'h00, 32'h0000_0003, rs);
		chk("bresp", {30'h0, rs}, {30'h0, pin_mux_pkg::RESP_OKAY});
		settle();
		chk("pair", pad_out, {30'h048D_159E, pd[1], pc[0]});
		$display("test mux done");
	endtask

	task automatic t_analog();
		wr(8'h20, 32'h0000_0031, rs);
		analog_busy <= 32'h0000_0005;
		settle();
		chk("b_oe", {31'h0, pad_oe[0]}, 32'h0);
		chk("b_ie", {31'h0, pad_ie[0]}, 32'h0);
		chk("b_on", analog_connect, 32'h1);
		chk("disturb", analog_disturb, 32'h4);
		rd(8'h14, rv, rs);
		chk("disturb_reg", rv, 32'h4);
		$display("test analog done");
	endtask

	task automatic t_irq();
		wr(8'h00, 32'h0000_010B, rs);
		pad_in <= 32'h0000_0108;
		settle();
		chk("nmi", {31'h0, nmi_irq}, 32'h1);
		chk("irq", {16'h0, ext_irq_line}, 32'h8);
		chk("wake", {24'h0, ext_wake_in}, 32'h8);
		$display("test irq done");
	endtask

	task automatic t_misc();
		reset_pad_n <= 1'b0;
		supply_good_pad <= 1'b1;
		debugger_detect <= 1'b1;
		dbg_swdio_oe <= 1'b1;
		dbg_swdio_out <= 1'b1;
		timer_cc_event <= 12'h001;
		i2c_mode <= 32'h0000_0002;
		swdio_pad_in <= 1'b1;
		settle();
		chk("swd_in", {31'h0, dbg_swdio_in}, 32'h1);
		chk("reset_in", {31'h0, reset_in_n}, 32'h0);
		chk("supply", {31'h0, main_supply_good}, 32'h1);
		chk("swd_oe", {31'h0, swdio_pad_oe}, 32'h1);
		chk("swd_out", {31'h0, swdio_pad_out}, 32'h1);
		chk("wave", {8'h0, waveform_out}, 32'h11);
		chk("i2c_block", {31'h0, pad_oe[1]}, 32'h0);
		rd(8'h10, rv, rs);
		chk("attached", {31'h0, rv[0]}, 32'h1);
		$display("test misc done");
	endtask

	task automatic t_special();
		osc_own <= 32'h0000_0010;
		osc_pad_oe <= 32'h0000_0010;
		pad_in <= 32'h0040_0118;
		// pin 22 on the clock function, pin 23 on a USB function
		wr(8'h4C, 32'h0000_0067, rs);
		wr(8'h00, 32'h00C0_011B, rs);
		settle();
		chk("osc_out", {31'h0, pad_out[4]}, 32'h0);
		chk("osc_ie", {31'h0, pad_ie[4]}, 32'h0);
		chk("osc_fin", {31'h0, periph_in[4]}, 32'h0);
		chk("usb_oe", {31'h0, pad_oe[23]}, 32'h0);
		chk("gclk_oe", {31'h0, pad_oe[22]}, 32'h1);
		chk("gclk_in", {31'h0, periph_in[7*32+22]}, 32'h1);
		rd(8'h10, rv, rs);
		chk("usb_bit", {31'h0, rv[1]}, 32'h0);
		$display("test special done");
	endtask

	initial begin
		aresetn <= 1'b0;
		{awvalid, wvalid, arvalid} <= 3'h0;
		{bready, rready} <= 2'h3;
		{awaddr, araddr, wdata} <= 48'h0;
		{awprot, arprot} <= 6'h0;
		wstrb <= 4'hF;
		{pad_in, analog_busy, i2c_mode} <= 96'h0;
		{osc_own, osc_pad_out, osc_pad_oe} <= 96'h0;
		{swdio_pad_in, debugger_detect, dbg_swdio_out, dbg_swdio_oe} <= 4'h0;
		reset_pad_n <= 1'b1;
		supply_good_pad <= 1'b0;
		timer_cc_event <= 12'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_reset();
		t_mux();
		t_analog();
		t_irq();
		t_misc();
		t_special();
		stop_test();
	end
endmodule
